// ### bmff_cfg.svh
// constants of the bus-matching fifo: depth, register map, fields, resets
// assumes nothing; included by the package and by the fifo module
`ifndef BMFF_CFG_SVH
`define BMFF_CFG_SVH
`define BMFF_DEPTH 11'h400
`define BMFF_DEPTH_FT 11'h401
`define BMFF_OFF_CTRL 8'h00
`define BMFF_OFF_AEOFF 8'h04
`define BMFF_OFF_STAT 8'h08
`define BMFF_OFF_ISTS 8'h0C
`define BMFF_OFF_ICLR 8'h10
`define BMFF_OFF_IEN 8'h14
`define BMFF_CTRL_IW 0
`define BMFF_CTRL_OW 2
`define BMFF_CTRL_BO 4
`define BMFF_CTRL_BM 5
`define BMFF_CTRL_FT 6
`define BMFF_EV_FULL 0
`define BMFF_EV_EMPTY 1
`define BMFF_EV_AE 2
`define BMFF_EV_OVF 3
`define BMFF_EV_UNF 4
`define BMFF_AEOFF_RST 11'h07F
`define BMFF_RESP_OK 2'h0
`define BMFF_RESP_ERR 2'h2
`endif

// ### bmff_fifo.sv
// bus-matching fifo with width packing, byte order and status flags
// assumes write and read logic on aclk; registers over axi4-lite
// Contract
// - 36 to 18 big order: first read gives bytes A B, second C D.
// - 36 to 18 little order: first read gives bytes C D, second A B.
// - 36 to 9 big order: reads give A, B, C, D on low nine bits.
// - 36 to 9 little order: reads give D, C, B, A on low nine bits.
// - 9 to 36: first byte lands on top if big order, bottom if little.
// - full flag clears one cycle after the read that frees space.
// - standard timing: empty flag clears one cycle after first write.
// - fall-through: output ready and data two cycles after first write.
// - almost-empty clears one cycle after level passes its offset.
// - fall-through depth is array plus one output word.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "bmff_cfg.svh"
module bmff_fifo import bmff_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write port
   input wire logic wr_en,
   input wire logic [35:0] wr_data,
   // read port
   input wire logic rd_en,
   output logic [35:0] rd_data,
   // flags and interrupt
   output logic full_flag_n,
   output logic empty_flag_n,
   output logic almost_empty_flag_n,
   output logic out_ready_n,
   output logic irq,
   // axi4-lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   // -----------------------------------------------------------------
   // lane helpers
   // -----------------------------------------------------------------
   function automatic logic [1:0] last_k(input bmff_wid_t w);
      last_k = (w == BMFF_W9) ? 2'h3 : ((w == BMFF_W18) ? 2'h1 : 2'h0);
   endfunction : last_k

   function automatic bmff_wid_t to_wid(input logic [1:0] v);
      to_wid = (v == 2'h1) ? BMFF_W18 : ((v == 2'h3) ? BMFF_W9 : BMFF_W36);
   endfunction : to_wid

   function automatic logic [35:0] lane_get(input logic [35:0] w,
      input bmff_wid_t wd, input logic le, input logic [1:0] k);
      logic [1:0] b;
      b = le ? k : 2'h3 - k;
      case (wd)
         BMFF_W18: lane_get = {18'h0, (le ^ k[0]) ? w[17:0] : w[35:18]};
         BMFF_W9: lane_get = {27'h0, w[9*b +: 9]};
         default: lane_get = w;
      endcase
   endfunction : lane_get

   function automatic logic [35:0] lane_put(input logic [35:0] w,
      input logic [35:0] d, input bmff_wid_t wd, input logic le,
      input logic [1:0] k);
      logic [1:0] b;
      b = le ? k : 2'h3 - k;
      lane_put = w;
      case (wd)
         BMFF_W18: begin
            if (le ^ k[0]) lane_put[17:0] = d[17:0];
            else lane_put[35:18] = d[17:0];
         end
         BMFF_W9: lane_put[9*b +: 9] = d[8:0];
         default: lane_put = d;
      endcase
   endfunction : lane_put

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   bmff_st_t st_q;
   bmff_st_t n;
   bmff_cfg_t ncfg;
   logic [35:0] mem_q [0:1023];
   logic [35:0] wd_word;
   logic [35:0] wword;
   logic [10:0] lvl_q;
   logic [10:0] lvl_d;
   logic [7:0] wa;
   logic [31:0] wdat;
   logic [3:0] wst;
   logic aw_h;
   logic w_h;
   logic mreset;
   logic wr_ok;
   logic rd_ok;
   logic push;
   logic pop;
   logic lastr;
   logic [4:0] clr;
   logic [4:0] ev;
   logic [8:0] first_lane_q;

   assign wd_word = mem_q[st_q.rptr];
   assign lvl_q = st_q.count + {10'h0, st_q.cfg.ft & st_q.hold_v};
   assign awready = ~st_q.aw_have & ~st_q.bvalid;
   assign wready = ~st_q.w_have & ~st_q.bvalid;
   assign arready = ~st_q.rvalid;
   assign wa = st_q.aw_have ? st_q.aw_addr : awaddr[7:0];
   assign wdat = st_q.w_have ? st_q.w_data : wdata;
   assign wst = st_q.w_have ? st_q.w_strb : wstrb;
   assign aw_h = st_q.aw_have | (awvalid & awready);
   assign w_h = st_q.w_have | (wvalid & wready);

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      n = st_q;
      mreset = 1'b0;
      clr = 5'h0;
      // settings taken only at master reset
      ncfg.bm = wdat[`BMFF_CTRL_BM];
      ncfg.le = wdat[`BMFF_CTRL_BO];
      ncfg.ft = wdat[`BMFF_CTRL_FT];
      ncfg.iw = ncfg.bm ? to_wid(wdat[`BMFF_CTRL_IW +: 2]) : BMFF_W36;
      ncfg.ow = ncfg.bm ? to_wid(wdat[`BMFF_CTRL_OW +: 2]) : BMFF_W36;
      if (ncfg.iw != BMFF_W36) ncfg.ow = BMFF_W36;
      // bus write: address and data in either order
      if (awvalid && awready) begin
         n.aw_have = 1'b1;
         n.aw_addr = awaddr[7:0];
      end
      if (wvalid && wready) begin
         n.w_have = 1'b1;
         n.w_data = wdata;
         n.w_strb = wstrb;
      end
      if (st_q.bvalid && bready) n.bvalid = 1'b0;
      if (aw_h && w_h && !st_q.bvalid) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `BMFF_RESP_OK;
         case (wa)
            `BMFF_OFF_CTRL: mreset = wst[0];
            `BMFF_OFF_AEOFF: begin
               if (wst[0]) n.ae_off[7:0] = wdat[7:0];
               if (wst[1]) n.ae_off[10:8] = wdat[10:8];
            end
            `BMFF_OFF_IEN: if (wst[0]) n.irq_en = wdat[4:0];
            `BMFF_OFF_ICLR: if (wst[0]) clr = wdat[4:0];
            `BMFF_OFF_STAT, `BMFF_OFF_ISTS: n.bresp = `BMFF_RESP_OK;
            default: n.bresp = `BMFF_RESP_ERR;
         endcase
      end
      // bus read
      if (st_q.rvalid && rready) n.rvalid = 1'b0;
      if (arvalid && arready) begin
         n.rvalid = 1'b1;
         n.rresp = `BMFF_RESP_OK;
         case (araddr[7:0])
            `BMFF_OFF_CTRL: n.rdata = {25'h0, st_q.cfg.ft, st_q.cfg.bm,
               st_q.cfg.le, st_q.cfg.ow, st_q.cfg.iw};
            `BMFF_OFF_AEOFF: n.rdata = {21'h0, st_q.ae_off};
            `BMFF_OFF_STAT: n.rdata = {5'h0, lvl_q, 13'h0, st_q.ae_n,
               st_q.empty_n, st_q.full_n};
            `BMFF_OFF_ISTS: n.rdata = {27'h0, st_q.irq_sts};
            `BMFF_OFF_ICLR: n.rdata = 32'h0;
            `BMFF_OFF_IEN: n.rdata = {27'h0, st_q.irq_en};
            default: begin
               n.rdata = 32'h0;
               n.rresp = `BMFF_RESP_ERR;
            end
         endcase
      end
      // write side packing
      wr_ok = wr_en & st_q.full_n;
      wword = lane_put(st_q.pack, wr_data, st_q.cfg.iw, st_q.cfg.le,
         st_q.in_lane);
      push = wr_ok & (st_q.in_lane == last_k(st_q.cfg.iw));
      if (wr_ok) begin
         n.pack = wword;
         n.in_lane = push ? 2'h0 : st_q.in_lane + 2'h1;
      end
      // read side unpacking
      lastr = st_q.out_lane == last_k(st_q.cfg.ow);
      rd_ok = rd_en & (st_q.cfg.ft ? st_q.hold_v : st_q.empty_n);
      if (rd_ok) n.out_lane = lastr ? 2'h0 : st_q.out_lane + 2'h1;
      if (!st_q.cfg.ft) begin
         pop = rd_ok & lastr;
         if (rd_ok) n.rd_data = lane_get(wd_word, st_q.cfg.ow,
            st_q.cfg.le, st_q.out_lane);
      end else begin
         // output word register adds one word of depth
         pop = (~st_q.hold_v | (rd_ok & lastr)) & st_q.empty_n;
         if (pop) begin
            n.hold = wd_word;
            n.hold_v = 1'b1;
         end else if (rd_ok && lastr) begin
            n.hold_v = 1'b0;
         end
         n.rd_data = lane_get(n.hold, st_q.cfg.ow, st_q.cfg.le,
            n.out_lane);
      end
      n.count = st_q.count + {10'h0, push} - {10'h0, pop};
      n.wptr = st_q.wptr + {9'h0, push};
      n.rptr = st_q.rptr + {9'h0, pop};
      // flags set at once, clear one cycle after their cause
      lvl_d = n.count + {10'h0, st_q.cfg.ft & n.hold_v};
      n.full_n = (st_q.count != `BMFF_DEPTH) &
         (n.count != `BMFF_DEPTH);
      n.empty_n = (st_q.count != 11'h0) & (n.count != 11'h0);
      n.ae_n = (lvl_q > st_q.ae_off) & (lvl_d > st_q.ae_off);
      // sticky events, a set beats a clear
      ev[`BMFF_EV_FULL] = st_q.full_n & ~n.full_n;
      ev[`BMFF_EV_EMPTY] = st_q.empty_n & ~n.empty_n;
      ev[`BMFF_EV_AE] = st_q.ae_n & ~n.ae_n;
      ev[`BMFF_EV_OVF] = wr_en & ~st_q.full_n;
      ev[`BMFF_EV_UNF] = rd_en & ~rd_ok;
      n.irq_sts = (st_q.irq_sts & ~clr) | ev;
      // master reset clears the data path and latches the settings
      if (mreset) begin
         n.cfg = ncfg;
         n.wptr = 10'h0;
         n.rptr = 10'h0;
         n.count = 11'h0;
         n.in_lane = 2'h0;
         n.out_lane = 2'h0;
         n.hold_v = 1'b0;
         n.rd_data = 36'h0;
         n.full_n = 1'b1;
         n.empty_n = 1'b0;
         n.ae_n = 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.full_n <= 1'b1;
         st_q.ae_off <= `BMFF_AEOFF_RST;
      end else begin
         st_q <= n;
      end
   end

   always_ff @(posedge aclk) begin
      if (push && !mreset) mem_q[st_q.wptr] <= wword;
   end

   always_ff @(posedge aclk) begin
      if (wr_ok && st_q.in_lane == 2'h0) first_lane_q <= wr_data[8:0];
   end

   assign rd_data = st_q.rd_data;
   assign full_flag_n = st_q.full_n;
   assign empty_flag_n = st_q.empty_n;
   assign almost_empty_flag_n = st_q.ae_n;
   assign out_ready_n = st_q.cfg.ft ? ~st_q.hold_v : ~st_q.empty_n;
   assign irq = |(st_q.irq_sts & st_q.irq_en);
   assign bvalid = st_q.bvalid;
   assign bresp = st_q.bresp;
   assign rvalid = st_q.rvalid;
   assign rdata = st_q.rdata;
   assign rresp = st_q.rresp;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || mreset);
   logic std_rd;
   assign std_rd = rd_ok & ~st_q.cfg.ft;

   property p_r01;
      std_rd && st_q.cfg.ow == BMFF_W18 && !st_q.cfg.le &&
         st_q.out_lane == 2'h0 |=> rd_data == {18'h0, $past(wd_word[35:18])};
   endproperty
   a_r01: assert property (p_r01) else $error("x18 big first half");
   property p_r02;
      std_rd && st_q.cfg.ow == BMFF_W18 && st_q.cfg.le &&
         st_q.out_lane == 2'h0 |=> rd_data == {18'h0, $past(wd_word[17:0])};
   endproperty
   a_r02: assert property (p_r02) else $error("x18 little half");
   property p_r03;
      std_rd && st_q.cfg.ow == BMFF_W9 && !st_q.cfg.le &&
         st_q.out_lane == 2'h3 |=> rd_data[8:0] == $past(wd_word[8:0]);
   endproperty
   a_r03: assert property (p_r03) else $error("x9 big last byte");
   property p_r04;
      std_rd && st_q.cfg.ow == BMFF_W9 && st_q.cfg.le &&
         st_q.out_lane == 2'h3 |=> rd_data[8:0] == $past(wd_word[35:27]);
   endproperty
   a_r04: assert property (p_r04) else $error("x9 little order");
   property p_r05;
      push && st_q.cfg.iw == BMFF_W9 |->
         (st_q.cfg.le ? wword[8:0] : wword[35:27]) == first_lane_q;
   endproperty
   a_r05: assert property (p_r05) else $error("x9 packing order");
   property p_r06;
      !full_flag_n && pop && !push |=> !full_flag_n ##1 full_flag_n;
   endproperty
   a_r06: assert property (p_r06) else $error("full clear delay");
   property p_r07;
      !st_q.cfg.ft && st_q.count == 11'h0 && push |=>
         !empty_flag_n ##1 empty_flag_n;
   endproperty
   a_r07: assert property (p_r07) else $error("empty clear delay");
   property p_r08;
      st_q.cfg.ft && !st_q.hold_v && st_q.count == 11'h0 && push |=>
         out_ready_n [*2] ##1 (!out_ready_n && rd_data == lane_get(
         st_q.hold, st_q.cfg.ow, st_q.cfg.le, 2'h0));
   endproperty
   a_r08: assert property (p_r08) else $error("ready delay");
   property p_r09;
      !almost_empty_flag_n && lvl_q <= st_q.ae_off && lvl_d > st_q.ae_off
         |=> !almost_empty_flag_n and
         (lvl_d > st_q.ae_off |=> almost_empty_flag_n);
   endproperty
   a_r09: assert property (p_r09) else $error("almost-empty delay");
   property p_r10;
      st_q.cfg.ft && !full_flag_n && st_q.hold_v |-> lvl_q == `BMFF_DEPTH_FT;
   endproperty
   a_r10: assert property (p_r10) else $error("fall-through depth");
   property p_r12;
      std_rd && st_q.cfg.ow == BMFF_W36 |=> rd_data == $past(wd_word);
   endproperty
   a_r12: assert property (p_r12) else $error("x36 pass-through");
   c_full: cover property (!full_flag_n ##1 full_flag_n);
   c_ft_ready: cover property (st_q.cfg.ft && $fell(out_ready_n));
   c_x9_read: cover property (std_rd && st_q.cfg.ow == BMFF_W9 && lastr);
endmodule : bmff_fifo
`default_nettype wire

// ### bmff_pkg.sv
// types of the bus-matching fifo
// assumes bmff_cfg.svh on the include path
package bmff_pkg;
`include "bmff_cfg.svh"
   typedef enum logic [1:0] {
      BMFF_W36 = 2'h0,
      BMFF_W18 = 2'h1,
      BMFF_W9 = 2'h3
   } bmff_wid_t;
   typedef struct packed {
      bmff_wid_t iw;
      bmff_wid_t ow;
      logic le;
      logic bm;
      logic ft;
   } bmff_cfg_t;
   typedef struct packed {
      bmff_cfg_t cfg;
      logic [10:0] ae_off;
      logic [4:0] irq_en;
      logic [4:0] irq_sts;
      logic [9:0] wptr;
      logic [9:0] rptr;
      logic [10:0] count;
      logic [1:0] in_lane;
      logic [1:0] out_lane;
      logic [35:0] pack;
      logic [35:0] hold;
      logic hold_v;
      logic full_n;
      logic empty_n;
      logic ae_n;
      logic [35:0] rd_data;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bmff_st_t;
endpackage : bmff_pkg

// ### bmff_writer.sv
// write-side logic model for the bus-matching fifo
// assumes push requests from the bench on aclk
`timescale 1ns/1ns
`default_nettype none
module bmff_writer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // requests
   input wire logic push,
   input wire logic [35:0] push_data,
   // write port
   output logic wr_en,
   output logic [35:0] wr_data
);
   // -----------------------------
   // lane driver, garbage when idle
   // -----------------------------
   always_ff @(posedge aclk) begin
      wr_en <= push && aresetn;
      if (!aresetn) begin
         wr_data <= 36'h5A5A5A5A5;
      end else begin
         wr_data <= push ? push_data : ~wr_data;
      end
   end
endmodule : bmff_writer
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the bus-matching fifo
// assumes bmff_pkg, bmff_fifo and bmff_writer compiled before
`timescale 1ns/1ns
`default_nettype none
`include "bmff_cfg.svh"
module tb_top;
   logic aclk, aresetn, push, rd_en, awvalid, wvalid, bready, arvalid;
   logic rready, wr_en, full_flag_n, empty_flag_n, almost_empty_flag_n;
   logic out_ready_n, irq, awready, wready, bvalid, arready, rvalid;
   logic [35:0] push_data, wr_data, rd_data, w;
   logic [31:0] awaddr, wdata, araddr, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   int num_errors, checks_done;
   int tab_i[10] = '{0, 0, 0, 0, 0, 0, 3, 3, 1, 1};
   int tab_o[10] = '{0, 0, 1, 1, 3, 3, 0, 0, 0, 0};
   // -----------------------------
   // instances
   // -----------------------------
   bmff_writer bmff_writer_inst (.aclk(aclk), .aresetn(aresetn),
      .push(push), .push_data(push_data), .wr_en(wr_en), .wr_data(wr_data));
   bmff_fifo bmff_fifo_inst (.aclk(aclk), .aresetn(aresetn), .wr_en(wr_en),
      .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
      .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
      .almost_empty_flag_n(almost_empty_flag_n), .out_ready_n(out_ready_n),
      .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // -----------------------------
   // expectations and checks
   // -----------------------------
   function automatic int lanes(input int c);
      return c == 0 ? 1 : (c == 1 ? 2 : 4);
   endfunction : lanes
   function automatic logic [35:0] lane(input logic [35:0] v, input int n,
      input int le, input int k);
      int wd;
      int idx;
      wd = 36 / n;
      idx = le ? k : n - 1 - k;
      return (v >> (idx * wd)) & ((36'h1 << wd) - 36'h1);
   endfunction : lane
   task automatic chk(input string nm, input logic [35:0] e,
      input logic [35:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic tmo(input int n);
      if (n >= 100) begin
         num_errors++;
         conclude();
      end
   endtask : tmo
   // -----------------------------
   // bus and port drivers
   // -----------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      rs = bresp;
      bready <= 1'b0;
      tmo(n);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      rv = rdata;
      rs = rresp;
      rready <= 1'b0;
      tmo(n);
   endtask : axr
   task automatic put_word(input logic [35:0] v, input int n, input int le);
      @(posedge aclk);
      for (int k = 0; k < n; k++) begin
         push <= 1'b1;
         push_data <= lane(v, n, le, k);
         @(posedge aclk);
      end
      push <= 1'b0;
      @(posedge aclk);
      #1;
   endtask : put_word
   task automatic fill(input int n);
      repeat (n) put_word({4'($urandom()), $urandom()}, 1, 0);
   endtask : fill
   task automatic rd(input int n, input logic [35:0] v, input int le);
      @(posedge aclk);
      rd_en <= 1'b1;
      for (int k = 0; k < n; k++) begin
         @(posedge aclk);
         #1;
         chk("rd_data", lane(v, n, le, k), rd_data);
      end
      rd_en <= 1'b0;
   endtask : rd
   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      {aresetn, push, rd_en, awvalid, wvalid, bready, arvalid, rready} = '0;
      {push_data, awaddr, wdata, araddr} = '0;
      wstrb = 4'hF;
      num_errors = 0;
      checks_done = 0;
      void'($urandom(32'hB99A));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk("empty_flag_n", 36'h0, {35'h0, empty_flag_n});
      chk("full_flag_n", 36'h1, {35'h0, full_flag_n});
      axr(8'h3C);
      chk("rresp", 36'h2, {34'h0, rs});
      chk("rdata", 36'h0, {4'h0, rv});
      axw(`BMFF_OFF_AEOFF, 32'h1);
      chk("bresp", 36'h0, {34'h0, rs});
      for (int i = 0; i < 10; i++) begin
         axw(`BMFF_OFF_CTRL, {26'h0, 1'b1, i[0], tab_o[i][1:0],
            tab_i[i][1:0]});
         w = {4'($urandom()), $urandom()};
         put_word(w, lanes(tab_i[i]), i % 2);
         chk("empty_flag_n", 36'h0, {35'h0, empty_flag_n});
         @(posedge aclk);
         #1;
         chk("empty_flag_n", 36'h1, {35'h0, empty_flag_n});
         chk("ae_n", 36'h0, {35'h0, almost_empty_flag_n});
         rd(lanes(tab_o[i]), w, i % 2);
      end
      axw(`BMFF_OFF_CTRL, 32'h20);
      fill(2);
      chk("ae_n", 36'h0, {35'h0, almost_empty_flag_n});
      @(posedge aclk);
      #1;
      chk("ae_n", 36'h1, {35'h0, almost_empty_flag_n});
      axw(`BMFF_OFF_CTRL, 32'h60);
      w = {4'($urandom()), $urandom()};
      put_word(w, 1, 0);
      @(posedge aclk);
      #1;
      chk("out_ready_n", 36'h1, {35'h0, out_ready_n});
      @(posedge aclk);
      #1;
      chk("out_ready_n", 36'h0, {35'h0, out_ready_n});
      chk("rd_data", w, rd_data);
      fill(1023);
      chk("full_flag_n", 36'h1, {35'h0, full_flag_n});
      fill(1);
      @(posedge aclk);
      #1;
      chk("full_flag_n", 36'h0, {35'h0, full_flag_n});
      axr(`BMFF_OFF_STAT);
      chk("level", 36'h401, {25'h0, rv[26:16]});
      axw(`BMFF_OFF_CTRL, 32'h20);
      axw(`BMFF_OFF_IEN, 32'h9);
      fill(1025);
      chk("full_flag_n", 36'h0, {35'h0, full_flag_n});
      chk("irq", 36'h1, {35'h0, irq});
      axr(`BMFF_OFF_ISTS);
      chk("ists", 36'h9, {4'h0, rv & 32'h9});
      @(posedge aclk);
      rd_en <= 1'b1;
      @(posedge aclk);
      rd_en <= 1'b0;
      #1;
      chk("full_flag_n", 36'h0, {35'h0, full_flag_n});
      repeat (2) @(posedge aclk);
      #1;
      chk("full_flag_n", 36'h1, {35'h0, full_flag_n});
      axw(`BMFF_OFF_ICLR, 32'h1F);
      #1;
      chk("irq", 36'h0, {35'h0, irq});
      conclude();
   end
endmodule : tb_top
`default_nettype wire
